// ---- logic/rcr_pkg.sv ----
// Purpose: Shared constants and types of the rotate, carry and rounding unit.
// Assumes: A 32-bit AHB-Lite register window with word-aligned registers.
// Notes:   Opcode layout is op class in bits 7:5, count flag in bit 4, register select in bits 1:0.
`default_nettype none
package rcr_pkg;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned NUM_WREGS      = 4;
    // Register byte offsets.
    localparam logic [7:0]  ADDR_INSTR     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_WREG0     = 8'h08;
    localparam logic [7:0]  ADDR_WREG3     = 8'h14;
    localparam logic [7:0]  ADDR_NONE      = 8'hFC;
    // Instruction byte fields.
    localparam int unsigned OP_LSB         = 5;
    localparam int unsigned CNT_FLAG_BIT   = 4;
    localparam logic [2:0]  OPC_RLC        = 3'h1;
    localparam logic [2:0]  OPC_RRC        = 3'h2;
    localparam logic [2:0]  OPC_STC        = 3'h3;
    localparam logic [2:0]  OPC_ROUND      = 3'h4;
    // Round takes the opcode byte plus six operand bytes, the first four form the division.
    localparam logic [2:0]  ROUND_OPND_BYTES = 3'h6;
    localparam logic [2:0]  ROUND_DIV_BYTES  = 3'h4;
    // Status bit positions.
    localparam int unsigned STS_BUSY       = 0;
    localparam int unsigned STS_DECODE     = 1;
    localparam int unsigned STS_C          = 2;
    localparam int unsigned STS_O          = 3;
    localparam int unsigned STS_S          = 4;
    localparam int unsigned STS_Z          = 5;
    // Values after reset.
    localparam logic [31:0] WREG_RST       = 32'h0000_0000;
    localparam logic [31:0] DIV_RST        = 32'h0000_0001;
    typedef enum logic [2:0] {ST_IDLE, ST_GET_COUNT, ST_GET_DIV, ST_ROTATE, ST_ROUND} rcr_state_e;
endpackage
`default_nettype wire

// ---- logic/rcr_rot_step.sv ----
// Purpose: One rotate-through-carry step with its flag results.
// Assumes: Pure combinational logic; the caller registers the results.
// Notes:   Overflow marks a change of the sign bit across the step.
`timescale 1ns/1ns
`default_nettype none
module rcr_rot_step #(
    parameter int unsigned W = 32
) (
    // Operand.
    input  wire logic [W-1:0] val,
    input  wire logic         carry_in,
    input  wire logic         dir_right,
    // Result.
    output logic      [W-1:0] res,
    output logic              carry_out,
    output logic              ovf,
    output logic              sign,
    output logic              zero
);
    always_comb
    begin
        if (dir_right)
        begin
            res       = {carry_in, val[W-1:1]};
            carry_out = val[0];
        end
        else
        begin
            res       = {val[W-2:0], carry_in};
            carry_out = val[W-1];
        end
        ovf  = res[W-1] ^ val[W-1];
        sign = res[W-1];
        zero = (res == '0);
    end
endmodule // rcr_rot_step
`default_nettype wire

// ---- logic/rcr_unit.sv ----
// Purpose: Rotate-through-carry, set-carry and rounding unit on an AHB-Lite register window.
// Assumes: Single word transfers; hready is this slave's own hreadyout.
// Notes:   Instruction bytes are written one at a time to the instruction register.
// How it works
// - Rotate left, carry into bit 0.
// - Counted left rotate repeats the carry step.
// - Rotate right, carry into top bit.
// - Counted right rotate repeats the carry step.
// - Flags C O S Z from last step.
// - One cycle, or count cycles after the count byte.
// - Rotate is one byte, two with count.
// - Round x by half-scale division, half up.
// - Round takes seven bytes, runs as sequence.
// - Set carry forces C, clears O.
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rcr_unit
    import rcr_pkg::*;
#(
    parameter int unsigned W = rcr_pkg::DATA_W
) (
    // Clock, reset and enable.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);
    import rcr_pkg::*;

    rcr_state_e     state_q, state_d;
    logic [W-1:0]   wreg_q [NUM_WREGS];
    logic [W-1:0]   wreg_d [NUM_WREGS];
    logic           carry_q, carry_d, ovf_q, ovf_d, sign_q, sign_d, zero_q, zero_d;
    logic [1:0]     sel_q, sel_d;
    logic           dir_q, dir_d;
    logic [3:0]     cnt_q, cnt_d;
    logic [W-1:0]   div_q, div_d;
    logic [2:0]     nbytes_q, nbytes_d;
    logic           pend_q, pend_d, pwrite_q, pwrite_d, hready_q, hready_d;
    logic [7:0]     paddr_q, paddr_d;
    logic [31:0]    hrdata_q, hrdata_d;
    logic           accept, wr_done, instr_wr, busy_q, eng_busy_d, do_step;
    logic [2:0]     op;
    logic [1:0]     st_sel;
    logic           st_dir;
    logic [W-1:0]   st_val, st_res, rotate_left_carry_op_exp, rotate_right_carry_op_exp, rem, round_res;
    logic           st_cy, st_ovf, st_sign, st_zero;

    assign hreadyout = hready_q;
    assign hrdata    = hrdata_q;
    assign accept    = hsel && htrans[1] && hready;
    assign wr_done   = pend_q && pwrite_q && hready_q;
    assign instr_wr  = wr_done && (paddr_q == ADDR_INSTR);
    assign op        = hwdata[OP_LSB +: 3];
    assign busy_q    = (state_q == ST_ROTATE) || (state_q == ST_ROUND);
    assign eng_busy_d = (state_d == ST_ROTATE) || (state_d == ST_ROUND);
    assign st_sel    = (state_q == ST_IDLE) ? hwdata[1:0] : sel_q;
    assign st_dir    = (state_q == ST_IDLE) ? (op == OPC_RRC) : dir_q;
    assign st_val    = wreg_q[st_sel];
    assign rotate_left_carry_op_exp  = {st_val[W-2:0], carry_q};
    assign rotate_right_carry_op_exp  = {carry_q, st_val[W-1:1]};
    assign rem       = (div_q == '0) ? '0 : (wreg_q[0] % div_q);
    assign round_res = (rem >= (div_q - rem)) ? (wreg_q[0] - rem + div_q) : (wreg_q[0] - rem);

    rcr_rot_step #(.W(W)) u_step (
        .val       (st_val),
        .carry_in  (carry_q),
        .dir_right (st_dir),
        .res       (st_res),
        .carry_out (st_cy),
        .ovf       (st_ovf),
        .sign      (st_sign),
        .zero      (st_zero)
    );

    // Instruction sequencing and datapath.
    always_comb
    begin
        state_d  = state_q;
        wreg_d   = wreg_q;
        carry_d  = carry_q;
        ovf_d    = ovf_q;
        sign_d   = sign_q;
        zero_d   = zero_q;
        sel_d    = sel_q;
        dir_d    = dir_q;
        cnt_d    = cnt_q;
        div_d    = div_q;
        nbytes_d = nbytes_q;
        do_step  = 1'b0;
        if (wr_done && (paddr_q >= ADDR_WREG0) && (paddr_q <= ADDR_WREG3))
        begin
            wreg_d[paddr_q[3:2] - 2'h2] = hwdata[W-1:0];
        end
        unique case (state_q)
            ST_IDLE:
            begin
                if (instr_wr)
                begin
                    sel_d = hwdata[1:0];
                    dir_d = (op == OPC_RRC);
                    if ((op == OPC_RLC) || (op == OPC_RRC))
                    begin
                        if (hwdata[CNT_FLAG_BIT])
                        begin
                            state_d = ST_GET_COUNT;
                        end
                        else
                        begin
                            do_step = 1'b1;
                        end
                    end
                    else if (op == OPC_STC)
                    begin
                        carry_d = 1'b1;
                        ovf_d   = 1'b0;
                    end
                    else if (op == OPC_ROUND)
                    begin
                        nbytes_d = 3'h0;
                        div_d    = '0;
                        state_d  = ST_GET_DIV;
                    end
                end
            end
            ST_GET_COUNT:
            begin
                if (instr_wr)
                begin
                    cnt_d   = hwdata[3:0];
                    state_d = (hwdata[3:0] != 4'h0) ? ST_ROTATE : ST_IDLE;
                end
            end
            ST_GET_DIV:
            begin
                if (instr_wr)
                begin
                    if (nbytes_q < ROUND_DIV_BYTES)
                    begin
                        div_d[{nbytes_q[1:0], 3'h0} +: 8] = hwdata[7:0];
                    end
                    nbytes_d = nbytes_q + 3'h1;
                    if (nbytes_q == ROUND_OPND_BYTES - 3'h1)
                    begin
                        state_d = ST_ROUND;
                    end
                end
            end
            ST_ROTATE:
            begin
                do_step = 1'b1;
                cnt_d   = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    state_d = ST_IDLE;
                end
            end
            ST_ROUND:
            begin
                wreg_d[0] = round_res;
                state_d   = ST_IDLE;
            end
        endcase
        if (do_step)
        begin
            wreg_d[st_sel] = st_res;
            carry_d = st_cy;
            ovf_d   = st_ovf;
            sign_d  = st_sign;
            zero_d  = st_zero;
        end
    end

    // Bus slave. Zero-wait reads sample state at the address phase, so a read right after a
    // write to the same register returns the old value.
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == ADDR_STATUS)
        begin
            v[STS_BUSY]   = busy_q;
            v[STS_DECODE] = (state_q == ST_GET_COUNT) || (state_q == ST_GET_DIV);
            v[STS_C]      = carry_q;
            v[STS_O]      = ovf_q;
            v[STS_S]      = sign_q;
            v[STS_Z]      = zero_q;
        end
        else if ((a >= ADDR_WREG0) && (a <= ADDR_WREG3))
        begin
            v[W-1:0] = wreg_q[a[3:2] - 2'h2];
        end
        return v;
    endfunction

    always_comb
    begin
        pend_d   = pend_q;
        pwrite_d = pwrite_q;
        paddr_d  = paddr_q;
        hready_d = hready_q;
        hrdata_d = hrdata_q;
        if (pend_q && hready_q)
        begin
            pend_d = 1'b0;
        end
        if (pend_q && !hready_q)
        begin
            hready_d = !eng_busy_d;
        end
        if (accept)
        begin
            pend_d   = 1'b1;
            pwrite_d = hwrite;
            paddr_d  = ((haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0)) ? haddr[7:0] : ADDR_NONE;
            hready_d = !(hwrite && eng_busy_d);
            hrdata_d = hwrite ? hrdata_q : read_mux(paddr_d);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q  <= ST_IDLE;
            for (int i = 0; i < NUM_WREGS; i++) wreg_q[i] <= WREG_RST[W-1:0];
            carry_q  <= 1'b0;
            ovf_q    <= 1'b0;
            sign_q   <= 1'b0;
            zero_q   <= 1'b0;
            sel_q    <= 2'h0;
            dir_q    <= 1'b0;
            cnt_q    <= 4'h0;
            div_q    <= DIV_RST[W-1:0];
            nbytes_q <= 3'h0;
            pend_q   <= 1'b0;
            pwrite_q <= 1'b0;
            paddr_q  <= ADDR_NONE;
            hready_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            hresp    <= 1'b0;
        end
        else if (ce)
        begin
            state_q  <= state_d;
            wreg_q   <= wreg_d;
            carry_q  <= carry_d;
            ovf_q    <= ovf_d;
            sign_q   <= sign_d;
            zero_q   <= zero_d;
            sel_q    <= sel_d;
            dir_q    <= dir_d;
            cnt_q    <= cnt_d;
            div_q    <= div_d;
            nbytes_q <= nbytes_d;
            pend_q   <= pend_d;
            pwrite_q <= pwrite_d;
            paddr_q  <= paddr_d;
            hready_q <= hready_d;
            hrdata_q <= hrdata_d;
            hresp    <= 1'b0;
        end
    end

    // Checks on the datapath and the sequencer.
    property p_rotate_left_carry_op_step;
        @(posedge hclk) disable iff (!hresetn)
        (ce && do_step && !st_dir) |=> (wreg_q[$past(st_sel)] == $past(rotate_left_carry_op_exp)) && (carry_q == $past(st_val[W-1]));
    endproperty
    a_rotate_left_carry_op_step: assert property (p_rotate_left_carry_op_step) else $error("Left rotate through carry wrong.");

    property p_rotate_right_carry_op_step;
        @(posedge hclk) disable iff (!hresetn)
        (ce && do_step && st_dir) |=> (wreg_q[$past(st_sel)] == $past(rotate_right_carry_op_exp)) && (carry_q == $past(st_val[0]));
    endproperty
    a_rotate_right_carry_op_step: assert property (p_rotate_right_carry_op_step) else $error("Right rotate through carry wrong.");

    property p_flags;
        @(posedge hclk) disable iff (!hresetn)
        (ce && do_step) |=> (sign_q == wreg_q[$past(st_sel)][W-1]) && (zero_q == (wreg_q[$past(st_sel)] == '0));
    endproperty
    a_flags: assert property (p_flags) else $error("Sign or zero flag does not match result.");

    property p_count3;
        @(posedge hclk) disable iff (!hresetn)
        (ce && (state_q == ST_GET_COUNT) && instr_wr && (hwdata[3:0] == 4'h3)) |=> busy_q [*3] ##1 !busy_q;
    endproperty
    a_count3: assert property (p_count3) else $error("Counted rotate did not take count cycles.");

    property p_last_step;
        @(posedge hclk) disable iff (!hresetn)
        (ce && (state_q == ST_ROTATE) && (cnt_q == 4'h1)) |=> (state_q == ST_IDLE) && !busy_q;
    endproperty
    a_last_step: assert property (p_last_step) else $error("Rotation ran past its count.");

    property p_two_byte;
        @(posedge hclk) disable iff (!hresetn)
        (ce && (state_q == ST_IDLE) && instr_wr && ((op == OPC_RLC) || (op == OPC_RRC)) && hwdata[CNT_FLAG_BIT])
        |=> (state_q == ST_GET_COUNT);
    endproperty
    a_two_byte: assert property (p_two_byte) else $error("Count byte not awaited.");

    property p_force_carry_op;
        @(posedge hclk) disable iff (!hresetn)
        (ce && (state_q == ST_IDLE) && instr_wr && (op == OPC_STC))
        |=> carry_q && !ovf_q && $stable(sign_q) && $stable(zero_q);
    endproperty
    a_force_carry_op: assert property (p_force_carry_op) else $error("Set carry gave wrong flags.");

    property p_round_len;
        @(posedge hclk) disable iff (!hresetn)
        (ce && (state_q == ST_GET_DIV) && instr_wr && (nbytes_q == 3'h5)) |=> (state_q == ST_ROUND) ##1 (state_q == ST_IDLE);
    endproperty
    a_round_len: assert property (p_round_len) else $error("Round did not start after seventh byte.");

    property p_round_val;
        @(posedge hclk) disable iff (!hresetn)
        (ce && (state_q == ST_ROUND) && (div_q == 32'h0000_000A) && (wreg_q[0] < 32'h0000_1000))
        |=> ((wreg_q[0] % 32'h0000_000A) == 32'h0) && ((wreg_q[0] - $past(wreg_q[0]) + 32'h4) < 32'hA);
    endproperty
    a_round_val: assert property (p_round_val) else $error("Rounding result is not the nearest step.");

    property p_stall;
        @(posedge hclk) disable iff (!hresetn)
        (pend_q && !hready_q) |-> busy_q;
    endproperty
    a_stall: assert property (p_stall) else $error("Wait state without a running rotation.");
endmodule // rcr_unit
`default_nettype wire

// ---- verification/rcr_seq_model.sv ----
// Purpose: Sequencer stand-in that issues single-word AHB-Lite transfers to the unit.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes:   Every wait is bounded; running out raises tmo instead of hanging the run.
`timescale 1ns/1ns
`default_nettype none
module rcr_seq_model (
    // Clock and answer.
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Request.
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    // Read result and hang flag.
    output var  logic        rd_v,
    output var  logic [31:0] rd_data,
    output var  logic        tmo
);
    initial
    begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_v = 1'h0;
        rd_data = 32'h0;
        tmo = 1'h0;
    end

    // Waits for hready sampled high at a rising edge.
    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'h1)
        begin
            k++;
            if (k > 200)
            begin
                tmo <= 1'h1;
                return;
            end
            @(posedge hclk);
        end
    endtask

    // Address phase held until taken, then data phase held until answered.
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        if (!w)
        begin
            rd_v <= 1'h1;
            rd_data <= hrdata;
        end
    endtask

    always @(posedge hclk)
    begin
        if (rd_v)
            rd_v <= 1'h0;
    end
endmodule // rcr_seq_model
`default_nettype wire

// ---- verification/rotate_carry_round_unit_tb_top.sv ----
// Purpose: Self-checking bench for the rotate, carry and rounding unit.
// Assumes: The sequencer model makes every transfer; read results are checked in issue order.
// Notes:   Registers and flags are mirrored here, so a stall that ends early shows as a stale read.
`timescale 1ns/1ns
`default_nettype none
module rotate_carry_round_unit_tb_top;
    import rcr_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic        hwrite;
    logic        hreadyout;
    logic        hresp;
    logic        rd_v;
    logic        tmo;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd_data;
    logic [31:0] rv;
    logic [31:0] wreg [4];
    logic [31:0] q [$];
    logic        c_f, o_f, s_f, z_f;
    int          n_errors, checked, seed, i, n_wait;

    rcr_unit i_dut (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata
    );
    rcr_seq_model i_seq (
        .hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .rd_v, .rd_data, .tmo
    );

    always #10 hclk = ~hclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge tmo)
    begin
        n_errors++;
        give_verdict();
    end

    // Wait states seen by the master; cleared by the scenario before the write it measures.
    always @(posedge hclk)
    begin
        if (hreadyout !== 1'h1)
            n_wait++;
    end

    // Results are compared in the order the reads were issued.
    always @(posedge hclk)
    begin
        if (rd_v === 1'h1)
        begin
            if (q.size() == 0)
            begin
                n_errors++;
                $display("ERROR at %0t: read with nothing expected", $time);
            end
            else
            begin
                check(rd_data, q.pop_front());
                check({31'h0, hresp}, 32'h0);
            end
        end
    end

    function automatic logic [31:0] sts_exp();
        return {26'h0, z_f, s_f, o_f, c_f, 2'h0};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_seq.xfer({24'h0, a}, 1'h1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        i_seq.xfer({24'h0, a}, 1'h0, 32'h0);
    endtask

    task automatic set_reg(input int rg, input logic [31:0] v);
        wreg[rg] = v;
        wr(ADDR_WREG0 + 8'(4 * rg), v);
    endtask

    task automatic set_carry();
        wr(ADDR_INSTR, {24'h0, OPC_STC, 5'h0});
        c_f = 1'h1;
        o_f = 1'h0;
        rd(ADDR_STATUS, sts_exp());
    endtask

    // One carry rotation of the mirror.
    task automatic step(input int rg, input logic right);
        logic [31:0] v;
        v = wreg[rg];
        wreg[rg] = right ? {c_f, v[31:1]} : {v[30:0], c_f};
        c_f = right ? v[0] : v[31];
        o_f = wreg[rg][31] ^ v[31];
        s_f = wreg[rg][31];
        z_f = (wreg[rg] == 32'h0);
    endtask

    task automatic rot_op(input int rg, input logic right, input logic cnt, input logic [3:0] n);
        logic [2:0] opc;
        int         k;
        opc = right ? OPC_RRC : OPC_RLC;
        wr(ADDR_INSTR, {24'h0, opc, cnt, 2'h0, rg[1:0]});
        if (cnt)
            wr(ADDR_INSTR, {28'h0, n});
        k = cnt ? int'(n) : 1;
        repeat (k) step(rg, right);
        // This write stalls until the last step, so the reads below see final values.
        n_wait = 0;
        wr(ADDR_NONE, 32'h0);
        check(n_wait, (k > 1) ? k - 1 : 0);
        rd(ADDR_WREG0 + 8'(4 * rg), wreg[rg]);
        rd(ADDR_STATUS, sts_exp());
    endtask

    task automatic round_op(input logic [31:0] x, input logic [31:0] dv);
        logic [31:0] rem;
        int          b;
        set_reg(0, x);
        wr(ADDR_INSTR, {24'h0, OPC_ROUND, 5'h0});
        for (b = 0; b < 6; b++)
            wr(ADDR_INSTR, {24'h0, b < 4 ? dv[8*b +: 8] : 8'hA5});
        if (dv != 32'h0)
        begin
            rem = x % dv;
            wreg[0] = ({1'h0, rem} * 2 >= {1'h0, dv}) ? x - rem + dv : x - rem;
        end
        wr(ADDR_NONE, 32'h0);
        rd(ADDR_WREG0, wreg[0]);
        rd(ADDR_STATUS, sts_exp());
    endtask

    initial
    begin
        hclk = 1'h0;
        hresetn = 1'h0;
        ce = 1'h1;
        seed = 32'hA6CB67C8;
        n_errors = 0;
        checked = 0;
        {c_f, o_f, s_f, z_f} = 4'h0;
        for (i = 0; i < 4; i++)
            wreg[i] = WREG_RST;
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(ADDR_STATUS, 32'h0);
        for (i = 0; i < 4; i++)
            rd(ADDR_WREG0 + 8'(4 * i), WREG_RST);
        $display("test reset done");
        set_reg(1, 32'h8000_0001);
        set_carry();
        rot_op(1, 1'h0, 1'h0, 4'h0);
        rot_op(1, 1'h1, 1'h0, 4'h0);
        $display("test single rotate done");
        set_reg(3, 32'h0000_0000);
        rot_op(3, 1'h1, 1'h1, 4'hF);
        rot_op(3, 1'h0, 1'h1, 4'h0);
        rot_op(2, 1'h0, 1'h1, 4'h1);
        rot_op(2, 1'h1, 1'h1, 4'h3);
        $display("test counted rotate done");
        for (i = 0; i < 10; i++)
        begin
            rv = $random(seed);
            set_reg(int'(rv[1:0]), $random(seed));
            if (rv[8])
                set_carry();
            rot_op(int'(rv[1:0]), rv[2], rv[3], rv[7:4]);
        end
        $display("test random rotate done");
        round_op(32'h0000_04D2, 32'h0000_000A);
        round_op(32'h0000_04D3, 32'h0000_000A);
        round_op(32'h0000_04D3, 32'h0000_0000);
        $display("test round done");
        wr(ADDR_NONE, $random(seed));
        rd(ADDR_NONE, 32'h0);
        rd(ADDR_WREG0, wreg[0]);
        // Op code zero is not decoded, so nothing may change.
        wr(ADDR_INSTR, 32'h0000_0000);
        rd(ADDR_INSTR, 32'h0);
        rd(ADDR_STATUS, sts_exp());
        $display("test unmapped done");
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        {c_f, o_f, s_f, z_f} = 4'h0;
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_WREG0, WREG_RST);
        $display("test second reset done");
        repeat (3) @(posedge hclk);
        give_verdict();
    end
endmodule // rotate_carry_round_unit_tb_top
`default_nettype wire
